// File: hdl/sst_pkg.sv
// Contract
// - Non-flag status fields load on hardware reset only
// - Reset-cause flags reload on every reset
// - Strap changes ignored until next hardware reset
// - Read-only revision code in bits 31:24
// - Pin-reset flag marks external reset pin
// - Watchdog flag marks watchdog timeout reset
// - Clock-update flag marks synthesizer update reset
// - Software flag marks service-word software reset
// - Writing F to bits 23:20 clears flags
// - Internal resets never re-latch strap values
// - 11-bit product code captured from strap pins
// - Watchdog acknowledged by 5A then A5 writes
// - Software reset by 123 then 321 writes
// - Second software-reset write needs supervisor mode
// - Each timer is a 27-bit down counter
// - Timer clock: crystal through the 8 or 4096 prescaler, or system
// - Count reaches zero: reload, raise pending
// - Live count readable without disturbing counting
// - Period 8, 4096 or 1 ticks times count+1
// - Enable low resets and stops timer
// - Pending sets at zero, write 1 clears
// - Pending sets at enable rising edge
package sst_pkg;
   // ----------------------------------------
   // Register byte addresses
   // ----------------------------------------
   localparam logic [31:0] ADDR_STATUS = 32'hffb00004;
   localparam logic [31:0] ADDR_SERVICE = 32'hffb0000c;
   localparam logic [31:0] ADDR_T1_CTRL = 32'hffb00010;
   localparam logic [31:0] ADDR_T1_STAT = 32'hffb00014;
   localparam logic [31:0] ADDR_T2_CTRL = 32'hffb00018;
   localparam logic [31:0] ADDR_T2_STAT = 32'hffb0001c;
   // ----------------------------------------
   // Status fields and codes
   // ----------------------------------------
   localparam int FLAG_MSB = 23;
   localparam int FLAG_LSB = 20;
   localparam int PID_W = 11;
   localparam int REV_MSB = 31;
   localparam int REV_LSB = 24;
   localparam logic [3:0] FLAG_PIN = 4'h8;
   localparam logic [3:0] FLAG_CLEAR = 4'hf;
   localparam logic [3:0] FLAGS_NONE = 4'h0;
   localparam logic [1:0] STRAP_SETTLE = 2'h2;
   // ----------------------------------------
   // Service word sequences
   // ----------------------------------------
   localparam logic [31:0] SVC_WD_FIRST = 32'h0000005a;
   localparam logic [31:0] SVC_WD_SECOND = 32'h000000a5;
   localparam logic [31:0] SVC_SR_FIRST = 32'h00000123;
   localparam logic [31:0] SVC_SR_SECOND = 32'h00000321;
   // ----------------------------------------
   // Timer fields and prescaler
   // ----------------------------------------
   localparam int CNT_W = 27;
   localparam int BIT_RUN = 31;
   localparam int BIT_IRQ_EN = 30;
   localparam int BIT_KIND = 29;
   localparam int BIT_DIV = 28;
   localparam int BIT_SRC = 27;
   localparam int BIT_PEND = 30;
   localparam int PRE_W = 12;
   localparam logic [PRE_W-1:0] PRE_SHORT_MASK = 12'h007;
   localparam logic [PRE_W-1:0] PRE_LONG_MASK = 12'hfff;
   localparam logic [PRE_W-1:0] PRE_STEP = 12'h001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 27'h0000000;
   localparam logic [CNT_W-1:0] CNT_ONE = 27'h0000001;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_WD = 3'b010,
      SEQ_SR = 3'b100
   } sst_seq_t;

   // Timer status word: reserved bits read as zero
   function automatic logic [31:0] sst_timer_word(input logic pend, input logic [CNT_W-1:0] cnt);
      logic [31:0] w;
      w = 32'h00000000;
      w[BIT_PEND] = pend;
      w[CNT_W-1:0] = cnt;
      return w;
   endfunction
endpackage

// File: hdl/sst_timer_if.sv
`timescale 1ns/100ps
interface sst_timer_if;
   import sst_pkg::*;
   logic srst;
   logic run_en;
   logic src_sys;
   logic div_long;
   logic [CNT_W-1:0] reload;
   logic tick_short;
   logic tick_long;
   logic pend_clr;
   logic [CNT_W-1:0] live;
   logic pend;
   modport ctl (output srst, run_en, src_sys, div_long, reload, tick_short, tick_long, pend_clr,
                input live, pend);
   modport tmr (input srst, run_en, src_sys, div_long, reload, tick_short, tick_long, pend_clr,
                output live, pend);
endinterface

// File: hdl/sst_timer.sv
`timescale 1ns/100ps
module sst_timer (
   input wire logic pclk,
   input wire logic presetn,
   sst_timer_if.tmr t
);
   import sst_pkg::*;

   logic [CNT_W-1:0] live_r, live_nxt;
   logic pend_r, pend_nxt;
   logic run_d_r, run_d_nxt;
   logic tick;
   logic set_pend;

   always_comb
   begin
      tick = t.src_sys ? 1'b1 : (t.div_long ? t.tick_long : t.tick_short);
      live_nxt = live_r;
      set_pend = 1'b0;
      run_d_nxt = t.run_en & ~t.srst;
      if (t.srst || !t.run_en)
      begin
         live_nxt = CNT_ZERO;
      end
      else if (!run_d_r)
      begin
         live_nxt = t.reload;
         set_pend = 1'b1;
      end
      else if (tick)
      begin
         if (live_r == CNT_ZERO)
         begin
            live_nxt = t.reload;
            set_pend = 1'b1;
         end
         else
         begin
            live_nxt = live_r - CNT_ONE;
         end
      end
      // A new event outranks a clear in the same cycle
      pend_nxt = t.srst ? 1'b0 : (set_pend | (pend_r & ~t.pend_clr));
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         live_r <= CNT_ZERO;
         pend_r <= 1'b0;
         run_d_r <= 1'b0;
      end
      else
      begin
         live_r <= live_nxt;
         pend_r <= pend_nxt;
         run_d_r <= run_d_nxt;
      end
   end

   assign t.live = live_r;
   assign t.pend = pend_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence run_rise_s;
      t.run_en && !run_d_r && !t.srst;
   endsequence
   sequence wrap_s;
      t.run_en && run_d_r && !t.srst && tick && live_r == CNT_ZERO;
   endsequence

   enable_sets_pend_a: assert property (@(posedge pclk) disable iff (!presetn)
      run_rise_s |=> pend_r && live_r == $past(t.reload))
      else $error("pending not raised on enable");
   wrap_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
      wrap_s |=> pend_r && live_r == $past(t.reload))
      else $error("no reload at zero");
   stopped_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      !t.run_en |=> live_r == CNT_ZERO)
      else $error("disabled timer not held at zero");
   count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
      t.run_en && run_d_r && !t.srst && tick && live_r != CNT_ZERO |=> live_r == $past(live_r) - CNT_ONE)
      else $error("count did not step down by one");
endmodule

// File: hdl/sst_seq.sv
`timescale 1ns/100ps
module sst_seq (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic srst,
   input wire logic wr_stb,
   input wire logic [31:0] wr_data,
   input wire logic wr_priv,
   output logic wd_ack,
   output logic soft_req
);
   import sst_pkg::*;

   sst_seq_t state_r, state_nxt;
   logic ack_r, ack_nxt;
   logic req_r, req_nxt;

   always_comb
   begin
      state_nxt = state_r;
      ack_nxt = 1'b0;
      req_nxt = 1'b0;
      if (srst)
      begin
         state_nxt = SEQ_IDLE;
      end
      else if (wr_stb)
      begin
         // Any stray value drops back to idle; a first word still arms its sequence
         state_nxt = SEQ_IDLE;
         case (state_r)
            SEQ_WD:
            begin
               if (wr_data == SVC_WD_SECOND)
               begin
                  ack_nxt = 1'b1;
               end
            end
            SEQ_SR:
            begin
               if (wr_data == SVC_SR_SECOND && wr_priv)
               begin
                  req_nxt = 1'b1;
               end
            end
            default:
            begin
               state_nxt = SEQ_IDLE;
            end
         endcase
         if (!ack_nxt && !req_nxt)
         begin
            if (wr_data == SVC_WD_FIRST)
            begin
               state_nxt = SEQ_WD;
            end
            else if (wr_data == SVC_SR_FIRST)
            begin
               state_nxt = SEQ_SR;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= SEQ_IDLE;
         ack_r <= 1'b0;
         req_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         ack_r <= ack_nxt;
         req_r <= req_nxt;
      end
   end

   assign wd_ack = ack_r;
   assign soft_req = req_r;

   sequence sr_second_s;
      state_r == SEQ_SR && wr_stb && !srst && wr_data == SVC_SR_SECOND;
   endsequence

   soft_needs_priv_a: assert property (@(posedge pclk) disable iff (!presetn)
      sr_second_s |=> soft_req == $past(wr_priv))
      else $error("software reset privilege check wrong");
   wd_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
      wd_ack |-> $past(state_r) == SEQ_WD && $past(wr_data) == SVC_WD_SECOND)
      else $error("watchdog ack without full sequence");
   stray_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_stb && !srst && wr_data != SVC_WD_FIRST && wr_data != SVC_SR_FIRST |=> state_r == SEQ_IDLE)
      else $error("tracker not idle after stray write");
endmodule

// File: hdl/sst_top.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
module sst_top #(
   parameter logic [7:0] REV_CODE = 8'h5c // Arbitrary identification value
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [2:0] pprot,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [sst_pkg::PID_W-1:0] strap_bus_pins,
   input wire logic crystal_ref_clk,
   input wire logic watchdog_timeout,
   input wire logic clock_update_reset,
   output logic watchdog_ack,
   output logic soft_reset_out,
   output logic timer_one_irq,
   output logic timer_one_fast_irq,
   output logic timer_two_irq,
   output logic timer_two_fast_irq
);
   import sst_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [3:0] flags_r, flags_nxt;
   logic [PID_W-1:0] board_product_code_r, board_product_code_nxt;
   logic [PID_W-1:0] strap_meta_r, strap_sync_r;
   logic [1:0] settle_r, settle_nxt;
   logic capture_r, capture_nxt;
   logic xtal_meta_r, xtal_sync_r, xtal_prev_r;
   logic [PRE_W-1:0] pre_cnt_r, pre_cnt_nxt;
   logic [31:0] ctrl1_r, ctrl1_nxt, ctrl2_r, ctrl2_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
   logic int_rst_r, int_rst_nxt;
   logic soft_out_r, soft_out_nxt;
   logic [3:0] irq_r, irq_nxt;
   logic [3:0] cause;
   logic wr_en, xtal_edge, wd_ack_w, soft_req_w, mapped;

   sst_timer_if t1_if ();
   sst_timer_if t2_if ();

   // ----------------------------------------
   // APB access decode
   // ----------------------------------------
   // Zero-wait slave: pready rises in the first access cycle
   assign wr_en = psel && penable && pready_r && pwrite;

   always_comb
   begin
      mapped = (paddr == ADDR_STATUS) || (paddr == ADDR_SERVICE) || (paddr == ADDR_T1_CTRL) ||
               (paddr == ADDR_T1_STAT) || (paddr == ADDR_T2_CTRL) || (paddr == ADDR_T2_STAT);
      pready_nxt = psel && !penable;
      pslverr_nxt = psel && !penable && !mapped;
      prdata_nxt = prdata_r;
      if (psel && !penable)
      begin
         prdata_nxt = 32'h00000000;
         if (!pwrite)
         begin
            case (paddr)
               ADDR_STATUS:
               begin
                  prdata_nxt[REV_MSB:REV_LSB] = REV_CODE;
                  prdata_nxt[FLAG_MSB:FLAG_LSB] = flags_r;
                  prdata_nxt[PID_W-1:0] = board_product_code_r;
               end
               ADDR_T1_CTRL: prdata_nxt = ctrl1_r;
               ADDR_T2_CTRL: prdata_nxt = ctrl2_r;
               ADDR_T1_STAT: prdata_nxt = sst_timer_word(t1_if.pend, t1_if.live);
               ADDR_T2_STAT: prdata_nxt = sst_timer_word(t2_if.pend, t2_if.live);
               default: prdata_nxt = 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r <= 32'h00000000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
      else
      begin
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // ----------------------------------------
   // Reset causes and status fields
   // ----------------------------------------
   // Internal resets clear the service tracker, timer controls and timers but leave strap data and the prescaler alone
   always_comb
   begin
      cause = {1'b0, watchdog_timeout, clock_update_reset, soft_req_w};
      int_rst_nxt = |cause;
      soft_out_nxt = soft_req_w;
      flags_nxt = flags_r;
      if (int_rst_nxt)
      begin
         flags_nxt = cause;
      end
      else if (wr_en && paddr == ADDR_STATUS && pwdata[FLAG_MSB:FLAG_LSB] == FLAG_CLEAR)
      begin
         flags_nxt = FLAGS_NONE;
      end
      settle_nxt = settle_r;
      capture_nxt = capture_r;
      board_product_code_nxt = board_product_code_r;
      if (capture_r)
      begin
         // Strap pins need two sync stages before they may be trusted
         if (settle_r == STRAP_SETTLE)
         begin
            board_product_code_nxt = strap_sync_r;
            capture_nxt = 1'b0;
         end
         else
         begin
            settle_nxt = settle_r + 2'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flags_r <= FLAG_PIN;
         board_product_code_r <= '0;
         settle_r <= 2'h0;
         capture_r <= 1'b1;
         int_rst_r <= 1'b0;
         soft_out_r <= 1'b0;
         strap_meta_r <= '0;
         strap_sync_r <= '0;
      end
      else
      begin
         flags_r <= flags_nxt;
         board_product_code_r <= board_product_code_nxt;
         settle_r <= settle_nxt;
         capture_r <= capture_nxt;
         int_rst_r <= int_rst_nxt;
         soft_out_r <= soft_out_nxt;
         strap_meta_r <= strap_bus_pins;
         strap_sync_r <= strap_meta_r;
      end
   end

   // ----------------------------------------
   // Service word tracker
   // ----------------------------------------
   sst_seq u_seq (
      .pclk(pclk),
      .presetn(presetn),
      .srst(int_rst_r),
      .wr_stb(wr_en && paddr == ADDR_SERVICE),
      .wr_data(pwdata),
      .wr_priv(pprot[0]),
      .wd_ack(wd_ack_w),
      .soft_req(soft_req_w)
   );

   // ----------------------------------------
   // Crystal reference and shared prescaler
   // ----------------------------------------
   // One prescaler serves both timers, so their crystal ticks stay aligned
   assign xtal_edge = xtal_sync_r && !xtal_prev_r;

   always_comb
   begin
      pre_cnt_nxt = xtal_edge ? pre_cnt_r + PRE_STEP : pre_cnt_r;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         xtal_meta_r <= 1'b0;
         xtal_sync_r <= 1'b0;
         xtal_prev_r <= 1'b0;
         pre_cnt_r <= '0;
      end
      else
      begin
         xtal_meta_r <= crystal_ref_clk;
         xtal_sync_r <= xtal_meta_r;
         xtal_prev_r <= xtal_sync_r;
         pre_cnt_r <= pre_cnt_nxt;
      end
   end

   // ----------------------------------------
   // Timer control registers
   // ----------------------------------------
   always_comb
   begin
      ctrl1_nxt = ctrl1_r;
      ctrl2_nxt = ctrl2_r;
      if (int_rst_r)
      begin
         ctrl1_nxt = 32'h00000000;
         ctrl2_nxt = 32'h00000000;
      end
      else if (wr_en && paddr == ADDR_T1_CTRL)
      begin
         ctrl1_nxt = pwdata;
      end
      else if (wr_en && paddr == ADDR_T2_CTRL)
      begin
         ctrl2_nxt = pwdata;
      end
      irq_nxt[0] = t1_if.pend && ctrl1_r[BIT_IRQ_EN] && !ctrl1_r[BIT_KIND];
      irq_nxt[1] = t1_if.pend && ctrl1_r[BIT_IRQ_EN] && ctrl1_r[BIT_KIND];
      irq_nxt[2] = t2_if.pend && ctrl2_r[BIT_IRQ_EN] && !ctrl2_r[BIT_KIND];
      irq_nxt[3] = t2_if.pend && ctrl2_r[BIT_IRQ_EN] && ctrl2_r[BIT_KIND];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl1_r <= 32'h00000000;
         ctrl2_r <= 32'h00000000;
         irq_r <= 4'h0;
      end
      else
      begin
         ctrl1_r <= ctrl1_nxt;
         ctrl2_r <= ctrl2_nxt;
         irq_r <= irq_nxt;
      end
   end

   // ----------------------------------------
   // Timer hookup
   // ----------------------------------------
   assign t1_if.srst = int_rst_r;
   assign t1_if.run_en = ctrl1_r[BIT_RUN];
   assign t1_if.src_sys = ctrl1_r[BIT_SRC];
   assign t1_if.div_long = ctrl1_r[BIT_DIV];
   assign t1_if.reload = ctrl1_r[CNT_W-1:0];
   assign t1_if.tick_short = xtal_edge && ((pre_cnt_r & PRE_SHORT_MASK) == PRE_SHORT_MASK);
   assign t1_if.tick_long = xtal_edge && ((pre_cnt_r & PRE_LONG_MASK) == PRE_LONG_MASK);
   assign t1_if.pend_clr = wr_en && paddr == ADDR_T1_STAT && pwdata[BIT_PEND];

   assign t2_if.srst = int_rst_r;
   assign t2_if.run_en = ctrl2_r[BIT_RUN];
   assign t2_if.src_sys = ctrl2_r[BIT_SRC];
   assign t2_if.div_long = ctrl2_r[BIT_DIV];
   assign t2_if.reload = ctrl2_r[CNT_W-1:0];
   assign t2_if.tick_short = t1_if.tick_short;
   assign t2_if.tick_long = t1_if.tick_long;
   assign t2_if.pend_clr = wr_en && paddr == ADDR_T2_STAT && pwdata[BIT_PEND];

   sst_timer u_timer_one (
      .pclk(pclk),
      .presetn(presetn),
      .t(t1_if.tmr)
   );

   sst_timer u_timer_two (
      .pclk(pclk),
      .presetn(presetn),
      .t(t2_if.tmr)
   );

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign watchdog_ack = wd_ack_w;
   assign soft_reset_out = soft_out_r;
   assign timer_one_irq = irq_r[0];
   assign timer_one_fast_irq = irq_r[1];
   assign timer_two_irq = irq_r[2];
   assign timer_two_fast_irq = irq_r[3];

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence status_clear_s;
      wr_en && paddr == ADDR_STATUS && pwdata[FLAG_MSB:FLAG_LSB] == FLAG_CLEAR;
   endsequence

   flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      status_clear_s ##0 !int_rst_nxt |=> flags_r == FLAGS_NONE)
      else $error("flags not cleared by F write");
   cause_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      int_rst_nxt |=> flags_r == $past(cause))
      else $error("reset cause not recorded");
   code_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !capture_r |=> board_product_code_r == $past(board_product_code_r))
      else $error("product code changed without hardware reset");
   soft_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      soft_req_w |=> flags_r[0] && soft_out_r ##1 !soft_out_r)
      else $error("software reset not flagged");
   rev_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == ADDR_STATUS |=> prdata_r[REV_MSB:REV_LSB] == REV_CODE)
      else $error("revision code not returned");
   status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == ADDR_STATUS |=>
         prdata_r[FLAG_MSB:FLAG_LSB] == $past(flags_r) && prdata_r[PID_W-1:0] == $past(board_product_code_r))
      else $error("status fields not returned");

   // A new presetn re-arms capture; internal resets never touch it
   sequence strap_load_s;
      capture_r && settle_r == STRAP_SETTLE;
   endsequence

   strap_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
      strap_load_s |=> board_product_code_r == $past(strap_sync_r) && !capture_r)
      else $error("product code not captured from straps");
   int_keeps_code_a: assert property (@(posedge pclk) disable iff (!presetn)
      int_rst_r && !capture_r |=> $stable(board_product_code_r) && !capture_r)
      else $error("internal reset re-latched product code");
   // Interrupt outputs lag pending by one cycle so they leave a flop
   irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl2_r[BIT_IRQ_EN] |=> !irq_r[2] && !irq_r[3])
      else $error("timer two interrupt while disabled");

   // ----------------------------------------
   // Register bus checks
   // ----------------------------------------
   // One access cycle only, so a master that waits for pready never stalls
   ready_one_cycle_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready_r ##1 !pready_r)
      else $error("pready not a single cycle pulse");
   unmapped_error_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !mapped |=> pready_r && pslverr_r)
      else $error("unmapped access without error");
endmodule

// File: tb/sys_status_service_timers_test.sv
`timescale 1ns/100ps
module sys_status_service_timers_test;
   import sst_pkg::*;
   localparam logic [7:0] REV = 8'h3b; // Arbitrary identification value
   localparam logic [10:0] PID = 11'h5a3;
   logic pclk, presetn, psel, penable, pwrite, crystal_ref_clk, watchdog_timeout, clock_update_reset;
   logic [31:0] paddr, pwdata, prdata, rdat;
   logic [2:0] pprot;
   logic pready, pslverr, watchdog_ack, soft_reset_out, rerr;
   wire [3:0] irqv;
   logic [10:0] strap_bus_pins;
   int fail_count = 0, checks_done = 0, ack_n = 0, soft_n = 0, cyc = 0, xedge = 0;

   sst_top #(.REV_CODE(REV)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .strap_bus_pins(strap_bus_pins), .crystal_ref_clk(crystal_ref_clk),
      .watchdog_timeout(watchdog_timeout), .clock_update_reset(clock_update_reset),
      .watchdog_ack(watchdog_ack), .soft_reset_out(soft_reset_out), .timer_one_irq(irqv[0]),
      .timer_one_fast_irq(irqv[1]), .timer_two_irq(irqv[2]), .timer_two_fast_irq(irqv[3]));

   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Crystal kept unrelated to pclk so the synchroniser sees real jitter
   initial
   begin
      crystal_ref_clk = 1'b0;
      forever #21 crystal_ref_clk = ~crystal_ref_clk;
   end
   always @(posedge crystal_ref_clk) xedge <= xedge + 1;
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (watchdog_ack === 1'b1) ack_n <= ack_n + 1;
      if (soft_reset_out === 1'b1) soft_n <= soft_n + 1;
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // ----------------------------------------
   // APB master: hold request until pready
   // ----------------------------------------
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [2:0] p);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pprot <= p;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [31:0] st(input logic [3:0] f);
      return {REV, f, 9'h000, PID};
   endfunction

   task automatic cause(input bit wd);
      @(posedge pclk);
      if (wd) watchdog_timeout <= 1'b1;
      else clock_update_reset <= 1'b1;
      @(posedge pclk);
      watchdog_timeout <= 1'b0;
      clock_update_reset <= 1'b0;
      repeat (3) @(posedge pclk);
      apb(1'b0, ADDR_STATUS, 32'h0, 3'h0);
   endtask

   // ----------------------------------------
   // Timer period measured between interrupt output rises
   // ----------------------------------------
   task automatic tmr(input logic [31:0] ca, input logic [31:0] ctl, input int k, input int lo,
                      input int hi, input bit xt);
      int s[3];
      int n;
      apb(1'b1, ca, ctl, 3'h0);
      for (int i = 0; i < 3; i++)
      begin
         while (irqv[k] !== 1'b1)
         begin
            @(posedge pclk);
         end
         s[i] = xt ? xedge : cyc;
         chk("other irq kind", 32'h0, {31'h0, irqv[k ^ 1]});
         apb(1'b1, ca + 32'h4, 32'h40000000, 3'h0);
         n = 0;
         while (irqv[k] !== 1'b0 && n < 8)
         begin
            @(posedge pclk);
            n++;
         end
      end
      chk("timer period", 32'h1, {31'h0, (s[2] - s[1]) >= lo && (s[2] - s[1]) <= hi});
      apb(1'b1, ca, 32'h0, 3'h0);
      apb(1'b0, ca + 32'h4, 32'h0, 3'h0);
      chk("count after stop", 32'h0, {5'h00, rdat[26:0]});
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (80000) @(posedge pclk);
      fail_count++;
      end_sim;
   end

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      pprot = 3'h0;
      watchdog_timeout = 1'b0;
      clock_update_reset = 1'b0;
      strap_bus_pins = PID;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (5) @(posedge pclk);
      apb(1'b0, ADDR_STATUS, 32'h0, 3'h0);
      chk("status after pin reset", st(4'h8), rdat);
      strap_bus_pins <= 11'h1c6;
      repeat (5) @(posedge pclk);
      apb(1'b0, ADDR_STATUS, 32'h0, 3'h0);
      chk("status after strap change", st(4'h8), rdat);
      apb(1'b1, ADDR_STATUS, 32'h00f00000, 3'h0);
      apb(1'b0, ADDR_STATUS, 32'h0, 3'h0);
      chk("status after clear", st(4'h0), rdat);
      cause(1'b1);
      chk("status after watchdog", st(4'h4), rdat);
      cause(1'b0);
      chk("status after clock update", st(4'h2), rdat);
      apb(1'b0, 32'hffb00008, 32'h0, 3'h0);
      chk("unmapped error", 32'h1, {31'h0, rerr});
      apb(1'b1, ADDR_SERVICE, SVC_WD_FIRST, 3'h0);
      apb(1'b1, ADDR_SERVICE, SVC_WD_SECOND, 3'h0);
      repeat (2) @(posedge pclk);
      chk("ack count", 32'h1, ack_n);
      apb(1'b1, ADDR_SERVICE, SVC_WD_FIRST, 3'h0);
      apb(1'b1, ADDR_SERVICE, 32'h00000077, 3'h0);
      apb(1'b1, ADDR_SERVICE, SVC_WD_SECOND, 3'h0);
      repeat (2) @(posedge pclk);
      chk("ack after broken sequence", 32'h1, ack_n);
      apb(1'b1, ADDR_SERVICE, SVC_SR_FIRST, 3'h0);
      apb(1'b1, ADDR_SERVICE, SVC_SR_SECOND, 3'h0);
      repeat (3) @(posedge pclk);
      chk("soft reset in user mode", 32'h0, soft_n);
      apb(1'b1, ADDR_SERVICE, SVC_SR_FIRST, 3'h0);
      apb(1'b1, ADDR_SERVICE, SVC_SR_SECOND, 3'h1);
      repeat (3) @(posedge pclk);
      chk("soft reset count", 32'h1, soft_n);
      apb(1'b0, ADDR_STATUS, 32'h0, 3'h0);
      chk("status after soft reset", st(4'h1), rdat);
      apb(1'b1, ADDR_T1_CTRL, 32'h37ffffff, 3'h0);
      apb(1'b0, ADDR_T1_CTRL, 32'h0, 3'h0);
      chk("control readback", 32'h37ffffff, rdat);
      tmr(ADDR_T1_CTRL, 32'hc8000009, 0, 10, 10, 1'b0);
      tmr(ADDR_T2_CTRL, 32'he0000003, 3, 31, 33, 1'b1);
      tmr(ADDR_T1_CTRL, 32'hd0000000, 0, 4095, 4097, 1'b1);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (5) @(posedge pclk);
      apb(1'b0, ADDR_STATUS, 32'h0, 3'h0);
      chk("status after second pin reset", {REV, 4'h8, 9'h000, 11'h1c6}, rdat);
      end_sim;
   end
endmodule
